// *** pkg/ppfm_pkg.sv ***
// Shared definitions for the port pin function mux block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package ppfm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin group carrier, one bit per pin of ports 2, 3, 6 and 12
  typedef struct packed {
    logic [2:0] clk;  // Clock / low-voltage port, three pins
    logic [1:0] bus;  // Serial-bus port, two open-drain pins
    logic [3:0] irq;  // Interrupt / timer port, four pins
    logic [3:0] ana;  // Analog-capable port, four pins
  } ppfm_pins_t;

  localparam int PIN_W = 13;  // Width of the pin carrier
  localparam int IRQ_N = 6;   // External interrupt inputs zero to five

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;  // Control-mode select per pin
  localparam logic [7:0] OFS_DIR    = 8'h04;  // Direction, one means input
  localparam logic [7:0] OFS_OUT    = 8'h08;  // Output latch
  localparam logic [7:0] OFS_PULL   = 8'h0C;  // Pull-up select
  localparam logic [7:0] OFS_LEVEL  = 8'h10;  // Pin levels, read only
  localparam logic [7:0] OFS_EDGE   = 8'h14;  // Valid edge, two bits per input
  localparam logic [7:0] OFS_STATUS = 8'h18;  // Sticky interrupt flags, W1C
  localparam logic [7:0] OFS_MASK   = 8'h1C;  // Interrupt enable mask
  localparam logic [7:0] OFS_DRV    = 8'h20;  // Driver section state, read only

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed masks
  localparam logic [12:0] MODE_RST  = 13'h000F;  // Analog port in analog mode
  localparam logic [12:0] DIR_RST   = 13'h1FFF;  // Every pin an input
  localparam logic [12:0] OUT_RST   = 13'h0000;  // Output latch cleared
  localparam logic [12:0] PULL_RST  = 13'h0000;  // No pull-up
  localparam logic [12:0] PULL_MASK = 13'h04F0;  // Interrupt port and clock pin 0
  localparam logic [11:0] EDGE_RST  = 12'h000;   // No valid edge

  // Valid edge codes; bit 0 rising, bit 1 falling
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Driver status bit positions
  localparam int DRV_RUN   = 0;
  localparam int DRV_ALERT = 1;
  localparam int DRV_BUCK  = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** design/ppfm_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin levels; output changes once stages two and three agree.
`timescale 1ns/1ps
module ppfm_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] stable_o
);

  logic [W-1:0] s1_q;  // First stage, read only by the second
  logic [W-1:0] s2_q;  // Second stage
  logic [W-1:0] s3_q;  // Third stage

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accept a bit only where stages two and three agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stable_o <= INIT;
    end else begin
      stable_o <= (s2_q & s3_q) | (stable_o & (s2_q ^ s3_q));
    end
  end

endmodule

// *** design/ppfm_edge.sv ***
// Selectable edge detector for a group of interrupt inputs.
// Assumes filtered levels on the same clock; pulse is combinational.
`timescale 1ns/1ps
module ppfm_edge #(
  parameter int N = 6
) (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           reset_i,
  // Levels and edge choice
  input  wire logic [N-1:0]   level_i,
  input  wire logic [2*N-1:0] sel_i,
  // One-cycle detection pulses
  output logic      [N-1:0]   pulse_o
);

  logic [N-1:0] prev_q;  // Level one cycle ago

  ////////////////////////////////////////////////////////////////////////////
  // Previous level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rising uses select bit 0, falling select bit 1
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pulse_o[i] = (level_i[i] & ~prev_q[i] & sel_i[2*i]) |
                   (~level_i[i] & prev_q[i] & sel_i[2*i+1]);
    end
  end

endmodule

// *** design/ppfm_top.sv ***
// Pin function mux for ports 2, 3, 6, 12 and the driver section links.
// Assumes an AXI4-Lite master, pad cells outside and port 0/1 logic on clk_i.
//
// Behaviour
// - Each pin chooses port or control function
// - Direction bit per pin sets input/output
// - Ports are four, four, two, three bits
// - Pull-ups on interrupt port, clock pin zero
// - Analog port starts in analog mode
// - Interrupt inputs detect chosen rising/falling/both edges
// - Serial-bus pins only ever pull low
// - Clock pin zero senses low-voltage level
// - Active-low reset pin resets the ports
// - Port0 bit1 pin drives driver enable
// - Dim inputs follow port3.3, port1.5/6/7
// - Dim pins stay usable as ordinary pins
// - Thermal event raises alert, stops driver
// - Alert feeds port3 bit0 and interrupt one
// - Mode low boost, mode high buck
`timescale 1ns/1ps
module ppfm_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                sys_reset_n_i,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_awaddr_i,
  input  wire logic                s_awvalid_i,
  output logic                     s_awready_o,
  input  wire logic [31:0]         s_wdata_i,
  input  wire logic [3:0]          s_wstrb_i,
  input  wire logic                s_wvalid_i,
  output logic                     s_wready_o,
  // AXI4-Lite write response
  output logic [1:0]               s_bresp_o,
  output logic                     s_bvalid_o,
  input  wire logic                s_bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_araddr_i,
  input  wire logic                s_arvalid_i,
  output logic                     s_arready_o,
  output logic [31:0]              s_rdata_o,
  output logic [1:0]               s_rresp_o,
  output logic                     s_rvalid_o,
  input  wire logic                s_rready_i,
  // Pads
  input  wire ppfm_pkg::ppfm_pins_t pad_in_i,
  output ppfm_pkg::ppfm_pins_t     pad_out_o,
  output ppfm_pkg::ppfm_pins_t     pad_oe_o,
  output ppfm_pkg::ppfm_pins_t     pad_pull_o,
  output logic [3:0]               analog_en_o,
  // Peripheral side
  input  wire logic                timer51_out_i,
  input  wire logic [1:0]          bus_drive_low_i,
  input  wire logic                port0_bit1_pin_i,
  input  wire logic [2:0]          port1_dim_pins_i,
  output ppfm_pkg::ppfm_pins_t     pin_level_o,
  output logic                     low_voltage_sense_o,
  output logic                     irq_o,
  // Driver section
  input  wire logic                thermal_trip_i,
  input  wire logic                mode_select_i,
  output logic                     drv_enable_o,
  output logic [3:0]               dim_o,
  output logic                     thermal_alert_o,
  output logic                     driver_run_o,
  output logic                     buck_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ppfm_pkg::ppfm_pins_t mode_q;      // One selects control function
  ppfm_pkg::ppfm_pins_t dir_q;       // One selects input
  ppfm_pkg::ppfm_pins_t out_q;       // Output latch
  ppfm_pkg::ppfm_pins_t pull_q;      // Pull-up select
  logic [11:0]          edge_q;      // Valid edge choices
  logic [5:0]           status_q;    // Sticky interrupt flags
  logic [5:0]           mask_q;      // Interrupt mask
  logic [15:0]          sync_w;      // Filtered pin levels
  ppfm_pkg::ppfm_pins_t pad_s;       // Filtered pad levels
  logic                 rst_pin_s;   // Filtered reset pin
  logic                 trip_s;      // Filtered thermal trip
  logic                 mode_s;      // Filtered mode select
  logic                 port_rst;    // Port state reset
  ppfm_pkg::ppfm_pins_t oe_d;        // Next output enables
  ppfm_pkg::ppfm_pins_t out_d;       // Next output values
  ppfm_pkg::ppfm_pins_t level_d;     // Next digital input view
  logic [5:0]           ext_lvl;     // Interrupt input levels
  logic [5:0]           ext_en;      // Interrupt inputs in use
  logic [5:0]           ext_pulse;   // Raw detected edges
  logic [5:0]           ext_hit;     // Edges on enabled inputs
  logic                 dim0_now;    // Level on port3 bit3

  // Bus slave state
  logic [ADDR_W-1:0]    awaddr_q;    // Captured write address
  logic                 aw_have_q;   // Write address held
  logic [31:0]          wdata_q;     // Captured write data
  logic [3:0]           wstrb_q;     // Captured byte strobes
  logic                 w_have_q;    // Write data held
  logic                 wr_fire;     // Write performed this cycle
  logic                 wr_ok;       // Write address mapped
  logic [31:0]          rd_word;     // Read mux result
  logic                 rd_ok;       // Read address mapped
  logic [15:0]          m_mode;      // Strobe-merged write values
  logic [15:0]          m_dir;
  logic [15:0]          m_out;
  logic [15:0]          m_pull;
  logic [15:0]          m_edge;
  logic [15:0]          m_mask;

  // Byte-strobe merge of the low half word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Word-aligned offset compare
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin filtering
  ppfm_sync #(
    .W    (16),
    .INIT (16'h2000)
  ) u_sync (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .async_i  ({mode_select_i, thermal_trip_i, sys_reset_n_i, pad_in_i}),
    .stable_o (sync_w)
  );

  assign pad_s     = sync_w[12:0];
  assign rst_pin_s = sync_w[13];
  assign trip_s    = sync_w[14];
  assign mode_s    = sync_w[15];
  // Low on the reset pin holds the port state in reset
  assign port_rst  = reset_i | ~rst_pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: write address channel
  assign wr_fire = aw_have_q & w_have_q & ~s_bvalid_o;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_awready_o <= 1'b1;
      aw_have_q   <= 1'b0;
      awaddr_q    <= '0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        awaddr_q    <= s_awaddr_i;
        aw_have_q   <= 1'b1;
        s_awready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_bvalid_o && s_bready_i) begin
        s_awready_o <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_wready_o <= 1'b1;
      w_have_q   <= 1'b0;
      wdata_q    <= '0;
      wstrb_q    <= '0;
    end else begin
      if (s_wvalid_i && s_wready_o) begin
        wdata_q    <= s_wdata_i;
        wstrb_q    <= s_wstrb_i;
        w_have_q   <= 1'b1;
        s_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      if (s_bvalid_o && s_bready_i) begin
        s_wready_o <= 1'b1;
      end
    end
  end

  // Write response; read-only offsets answer OKAY and ignore data
  assign wr_ok = hit(awaddr_q, ppfm_pkg::OFS_MODE) | hit(awaddr_q, ppfm_pkg::OFS_DIR) |
                 hit(awaddr_q, ppfm_pkg::OFS_OUT) | hit(awaddr_q, ppfm_pkg::OFS_PULL) |
                 hit(awaddr_q, ppfm_pkg::OFS_LEVEL) | hit(awaddr_q, ppfm_pkg::OFS_EDGE) |
                 hit(awaddr_q, ppfm_pkg::OFS_STATUS) | hit(awaddr_q, ppfm_pkg::OFS_MASK) |
                 hit(awaddr_q, ppfm_pkg::OFS_DRV);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= ppfm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid_o <= 1'b1;
      s_bresp_o  <= wr_ok ? ppfm_pkg::RESP_OKAY : ppfm_pkg::RESP_SLVERR;
    end else if (s_bready_i) begin
      s_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (hit(s_araddr_i, ppfm_pkg::OFS_MODE)) begin
      rd_word = {19'h00000, mode_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_DIR)) begin
      rd_word = {19'h00000, dir_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_OUT)) begin
      rd_word = {19'h00000, out_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_PULL)) begin
      rd_word = {19'h00000, pull_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_LEVEL)) begin
      rd_word = {19'h00000, pin_level_o};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_EDGE)) begin
      rd_word = {20'h00000, edge_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_STATUS)) begin
      rd_word = {26'h0000000, status_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_MASK)) begin
      rd_word = {26'h0000000, mask_q};
    end else if (hit(s_araddr_i, ppfm_pkg::OFS_DRV)) begin
      rd_word = {29'h00000000, buck_mode_o, thermal_alert_o, driver_run_o};
    end else begin
      rd_ok = 1'b0;  // Unmapped
    end
  end

  // Read channel, one word in flight
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_arready_o <= 1'b1;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= '0;
      s_rresp_o   <= ppfm_pkg::RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b1;
      s_rdata_o   <= rd_word;
      s_rresp_o   <= rd_ok ? ppfm_pkg::RESP_OKAY : ppfm_pkg::RESP_SLVERR;
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o  <= 1'b0;
      s_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port configuration registers
  assign m_mode = merge16({3'h0, mode_q}, wdata_q, wstrb_q);
  assign m_dir  = merge16({3'h0, dir_q}, wdata_q, wstrb_q);
  assign m_out  = merge16({3'h0, out_q}, wdata_q, wstrb_q);
  assign m_pull = merge16({3'h0, pull_q}, wdata_q, wstrb_q);
  assign m_edge = merge16({4'h0, edge_q}, wdata_q, wstrb_q);
  assign m_mask = merge16({10'h000, mask_q}, wdata_q, wstrb_q);

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      mode_q <= ppfm_pkg::MODE_RST;
      dir_q  <= ppfm_pkg::DIR_RST;
      out_q  <= ppfm_pkg::OUT_RST;
      pull_q <= ppfm_pkg::PULL_RST;
      edge_q <= ppfm_pkg::EDGE_RST;
      mask_q <= '0;
    end else if (wr_fire) begin
      // Per-pin function choice
      if (hit(awaddr_q, ppfm_pkg::OFS_MODE)) begin
        mode_q <= m_mode[12:0];
      end
      // Per-pin direction
      if (hit(awaddr_q, ppfm_pkg::OFS_DIR)) begin
        dir_q <= m_dir[12:0];
      end
      if (hit(awaddr_q, ppfm_pkg::OFS_OUT)) begin
        out_q <= m_out[12:0];
      end
      // Bits without a pull-up stay zero
      if (hit(awaddr_q, ppfm_pkg::OFS_PULL)) begin
        pull_q <= m_pull[12:0] & ppfm_pkg::PULL_MASK;
      end
      if (hit(awaddr_q, ppfm_pkg::OFS_EDGE)) begin
        edge_q <= m_edge[11:0];
      end
      if (hit(awaddr_q, ppfm_pkg::OFS_MASK)) begin
        mask_q <= m_mask[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive per port
  always_comb begin
    // Analog port: digital output only in port mode
    oe_d.ana  = ~mode_q.ana & ~dir_q.ana;
    out_d.ana = out_q.ana;
    // Interrupt port: bit 3 carries the timer output in control mode
    oe_d.irq  = mode_q.irq & 4'h8 | ~mode_q.irq & 4'hF;
    oe_d.irq  = oe_d.irq & ~dir_q.irq;
    out_d.irq = {mode_q.irq[3] ? timer51_out_i : out_q.irq[3], out_q.irq[2:0]};
    // Serial-bus port: drive low only, never high
    oe_d.bus  = mode_q.bus & bus_drive_low_i | ~mode_q.bus & ~dir_q.bus & ~out_q.bus;
    out_d.bus = 2'h0;
    // Clock port: control functions are inputs
    oe_d.clk  = ~mode_q.clk & ~dir_q.clk;
    out_d.clk = out_q.clk;
  end

  // Digital input view; analog-mode pins read zero, alert shares port3 bit0
  always_comb begin
    level_d        = pad_s;
    level_d.ana    = pad_s.ana & ~mode_q.ana;
    level_d.irq[0] = pad_s.irq[0] | thermal_alert_o;
  end

  // Pad outputs and peripheral view, all registered
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      pad_oe_o    <= '0;
      pad_out_o   <= '0;
      pad_pull_o  <= '0;
      analog_en_o <= 4'hF;
      pin_level_o <= '0;
    end else begin
      pad_oe_o    <= oe_d;
      pad_out_o   <= out_d;
      pad_pull_o  <= pull_q & dir_q;
      analog_en_o <= mode_q.ana;
      pin_level_o <= level_d;
    end
  end

  // Low-voltage sense path on clock pin zero in control mode
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      low_voltage_sense_o <= 1'b0;
    end else begin
      low_voltage_sense_o <= mode_q.clk[0] & pad_s.clk[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt inputs
  assign ext_lvl = {port1_dim_pins_i[1], level_d.irq, pad_s.clk[0]};
  assign ext_en  = {1'b1, mode_q.irq, mode_q.clk[0]};

  ppfm_edge #(
    .N (ppfm_pkg::IRQ_N)
  ) u_edge (
    .clk_i   (clk_i),
    .reset_i (port_rst),
    .level_i (ext_lvl),
    .sel_i   (edge_q),
    .pulse_o (ext_pulse)
  );

  assign ext_hit = ext_pulse & ext_en;

  // Sticky flags, set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      status_q <= '0;
    end else if (wr_fire && hit(awaddr_q, ppfm_pkg::OFS_STATUS) && wstrb_q[0]) begin
      status_q <= (status_q & ~wdata_q[5:0]) | ext_hit;
    end else begin
      status_q <= status_q | ext_hit;
    end
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver section links
  // Dim 0 sees the resolved port3 bit3 level; the pin keeps its own uses
  assign dim0_now = oe_d.irq[3] ? out_d.irq[3] : pad_s.irq[3];

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      drv_enable_o    <= 1'b0;
      dim_o           <= 4'h0;
      thermal_alert_o <= 1'b0;
      driver_run_o    <= 1'b0;
      buck_mode_o     <= 1'b0;
    end else begin
      drv_enable_o    <= port0_bit1_pin_i;
      dim_o           <= {port1_dim_pins_i, dim0_now};
      thermal_alert_o <= trip_s;
      driver_run_o    <= port0_bit1_pin_i & ~trip_s;
      buck_mode_o     <= mode_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  analog_reset_mode_a: assert property (port_rst |=> mode_q.ana == 4'hF)
    else $error("analog port not in analog mode after reset");
  dir_reset_in_a: assert property (port_rst ##1 port_rst |=> pad_oe_o == '0)
    else $error("pin driven during reset");
  bus_low_only_a: assert property (pad_out_o.bus == 2'h0)
    else $error("serial-bus pin driven high");
  bus_release_a: assert property (!port_rst |=>
    (pad_oe_o.bus & $past(~mode_q.bus & out_q.bus)) == 2'h0)
    else $error("serial-bus pin driven with latch high");
  pullup_allowed_a: assert property ((pad_pull_o & ~ppfm_pkg::PULL_MASK) == '0)
    else $error("pull-up on pin without one");
  dim_route_a: assert property (!port_rst |=> dim_o[3:1] == $past(port1_dim_pins_i))
    else $error("dim inputs do not follow port1 pins");
  enable_route_a: assert property (!port_rst |=> drv_enable_o == $past(port0_bit1_pin_i))
    else $error("driver enable does not follow port0 bit1");
  thermal_stop_a: assert property (thermal_alert_o |-> !driver_run_o)
    else $error("driver runs during thermal alert");
  alert_to_pin_a: assert property (thermal_alert_o && !port_rst |=> pin_level_o.irq[0])
    else $error("alert not seen on port3 bit0");
  edge_sticky_a: assert property (!port_rst |=> (status_q & $past(ext_hit)) == $past(ext_hit))
    else $error("detected edge lost");
  mode_follow_a: assert property (!port_rst |=> buck_mode_o == $past(mode_s))
    else $error("buck mode does not follow mode input");

endmodule

// *** tb/ppfm_board.sv ***
// Board model: resolves each pad from driver, pull-up and board level.
// Assumes one level per pin from the bench; serial-bus lines pulled up.
`timescale 1ns/1ps
module ppfm_board (
  // Pad side of the block
  input  wire ppfm_pkg::ppfm_pins_t out_i,
  input  wire ppfm_pkg::ppfm_pins_t oe_i,
  input  wire ppfm_pkg::ppfm_pins_t pull_i,
  // Board levels
  input  wire ppfm_pkg::ppfm_pins_t ext_i,
  output ppfm_pkg::ppfm_pins_t      lvl_o
);
  // Driven pin wins; released bus lines float high
  assign lvl_o = (oe_i & out_i) | (~oe_i & (pull_i | ext_i | 13'h0300));
endmodule

// *** tb/ppfm_top_tb.sv ***
// Bench for the pin mux: bus tasks, pad, interrupt and driver checks.
// Assumes ppfm_top with an 8-bit bus address and the board model.
`timescale 1ns/1ps
module ppfm_top_tb;
  logic                 clk_i = 0, reset_i = 1, sys_n = 1, awv = 0, wv = 0, bry = 0;
  logic                 arv = 0, rry = 0, pb = 0, trip = 0, msel = 0, tmr = 0;
  logic                 awr, wrd, bv, arr, rv, lvs, irq, den, alert, run, buck;
  logic [7:0]           aw = 0, ar = 0;
  logic [31:0]          wd = 0, rdo;
  logic [2:0]           p1 = 0;
  logic [1:0]           bdl = 0, br, rr, wr_resp;
  logic [3:0]           aen, dim;
  ppfm_pkg::ppfm_pins_t ext = 0, pin, pout, poe, ppull, plvl;
  int                   err_total = 0, tests_run = 0;
  ppfm_top i_ppfm_top (
    .clk_i(clk_i), .reset_i(reset_i), .sys_reset_n_i(sys_n),
    .s_awaddr_i(aw), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd),
    .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wrd), .s_bresp_o(br),
    .s_bvalid_o(bv), .s_bready_i(bry), .s_araddr_i(ar), .s_arvalid_i(arv),
    .s_arready_o(arr), .s_rdata_o(rdo), .s_rresp_o(rr), .s_rvalid_o(rv),
    .s_rready_i(rry), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe),
    .pad_pull_o(ppull), .analog_en_o(aen), .timer51_out_i(tmr),
    .bus_drive_low_i(bdl), .port0_bit1_pin_i(pb), .port1_dim_pins_i(p1),
    .pin_level_o(plvl), .low_voltage_sense_o(lvs), .irq_o(irq),
    .thermal_trip_i(trip), .mode_select_i(msel), .drv_enable_o(den),
    .dim_o(dim), .thermal_alert_o(alert), .driver_run_o(run), .buck_mode_o(buck));
  ppfm_board i_ppfm_board (.out_i(pout), .oe_i(poe), .pull_i(ppull), .ext_i(ext), .lvl_o(pin));
  always #50 clk_i = ~clk_i;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bus write, each channel released when taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end while (!bv);
    wr_resp = br;
    bry <= 1'h0;
  endtask
  // Bus read, data and response compared
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] r);
    @(posedge clk_i);
    ar <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rry <= 1'h0;
    chk(rdo, exp);
    chk(32'(rr), 32'(r));
  endtask
  // Verdict
  task automatic stop_test;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #2000000;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk(32'(aen), 32'hF);
    chk(32'(poe), 32'h0);
    rd_chk(8'h00, 32'h000F, 2'h0);
    rd_chk(8'h04, 32'h1FFF, 2'h0);
    wr_reg(8'h0C, 32'hFFFF);
    chk(32'(wr_resp), 32'h0);
    rd_chk(8'h0C, 32'h04F0, 2'h0);
    chk(32'(ppull), 32'h04F0);
    wr_reg(8'h0C, 32'h0);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h08, 32'h0155);
    wr_reg(8'h04, 32'h0);
    repeat (8) @(posedge clk_i);
    chk(32'(aen), 32'h0);
    chk(32'(poe), 32'h1EFF);
    chk(32'(pout.bus), 32'h0);
    chk(32'(plvl), 32'h0155);
    rd_chk(8'h40, 32'h0, 2'h2);
    wr_reg(8'h40, 32'h1);
    chk(32'(wr_resp), 32'h2);
    // Edge codes on three inputs
    wr_reg(8'h04, 32'h1FFF);
    wr_reg(8'h00, 32'h04F0);
    wr_reg(8'h14, 32'h0039);
    wr_reg(8'h1C, 32'h003F);
    wr_reg(8'h18, 32'h003F);
    ext <= 13'h0430;
    repeat (10) @(posedge clk_i);
    rd_chk(8'h18, 32'h5, 2'h0);
    chk(32'(irq), 32'h1);
    chk(32'(lvs), 32'h1);
    wr_reg(8'h18, 32'h5);
    rd_chk(8'h18, 32'h0, 2'h0);
    chk(32'(irq), 32'h0);
    ext <= 13'h0400;
    repeat (10) @(posedge clk_i);
    rd_chk(8'h18, 32'h6, 2'h0);
    wr_reg(8'h1C, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    // Driver links
    pb <= 1'h1;
    p1 <= 3'h5;
    ext <= 13'h0480;
    repeat (8) @(posedge clk_i);
    chk(32'(dim), 32'hB);
    chk(32'(den), 32'h1);
    chk(32'(run), 32'h1);
    // Timer drives port3 bit3; serial-bus peripheral pulls one line low
    tmr <= 1'h1;
    bdl <= 2'h1;
    ext <= 13'h0400;
    wr_reg(8'h00, 32'h07F0);
    wr_reg(8'h04, 32'h1F7F);
    repeat (8) @(posedge clk_i);
    chk(32'(poe), 32'h0180);
    chk(32'(pout), 32'h00D5);
    chk(32'(plvl.bus), 32'h2);
    chk(32'(dim), 32'hB);
    trip <= 1'h1;
    msel <= 1'h1;
    repeat (8) @(posedge clk_i);
    rd_chk(8'h20, 32'h6, 2'h0);
    chk(32'(plvl.irq[0]), 32'h1);
    sys_n <= 1'h0;
    repeat (8) @(posedge clk_i);
    sys_n <= 1'h1;
    repeat (8) @(posedge clk_i);
    rd_chk(8'h00, 32'h000F, 2'h0);
    stop_test;
  end
endmodule
